// *** hw/dbs_consts.svh ***
// Constants of the burst-of-two DDR SRAM interface block
// Functional notes
// - Impedance evaluation runs periodically; interval counter restarts after each.
// - Each evaluation moves a code at most one step toward target.
// - Drive strength is a binary weighted code of discrete steps.
// - Input termination stays active always; it cannot be switched off.
// - Select low gives strong termination 0.3 ref; high gives weak 0.6.
// - Termination code recalibrates periodically with the same stepping scheme.
// - DLL resets on disable low or clocks stopped over 30 ns.
// - Select low: data drivers off one cycle, 2.0 after nop/write.
// - Select high: drivers off likewise; termination sets the line level.
// - Read beat one driven at K edge n+2, beat two half later.
// - Each write byte stored only when its strobe is low that beat.
// - All strobes high in both beats aborts the write entirely.
// - Load strobe high ignores commands; deselect after pending bursts.
// - Read captured at K rise with load low and select high.
// - Strobe k gates data bits 9k to 9k+8.
// - First write data expected at K rise after the command edge.
`ifndef DBS_CONSTS_SVH
`define DBS_CONSTS_SVH

`define DBS_CLK_PERIOD_NS 100
`define DBS_STOP_NS       30
`define DBS_STOP_CYC      ((`DBS_STOP_NS + `DBS_CLK_PERIOD_NS - 1) / \
                           `DBS_CLK_PERIOD_NS)
`define DBS_INIT_US       20
`define DBS_INIT_CYC      ((`DBS_INIT_US * 1000 + `DBS_CLK_PERIOD_NS - 1) / \
                           `DBS_CLK_PERIOD_NS)
`define DBS_LOCK_KCYC     2048
`define DBS_BYTE_W        9

`define DBS_OFF_CTRL      4'h0
`define DBS_OFF_STAT      4'h4
`define DBS_OFF_IVAL      4'h8
`define DBS_CTRL_CAL_EN   0
`define DBS_CTRL_EVAL     1
`define DBS_STAT_LOCKED   0
`define DBS_STAT_INIT     1
`define DBS_STAT_TSEL     2
`define DBS_STAT_DRV      8
`define DBS_STAT_TRM      16
`define DBS_IVAL_RST      32'h0000_0400
`define DBS_CODE_RST      6'h20

`define DBS_STRONG_NUM    12'h003
`define DBS_WEAK_NUM      12'h006
`define DBS_TERM_DEN      12'h00A

`define DBS_WR_B1_STG     1
`define DBS_WR_B2_STG     2
`define DBS_RD_B1_STG     3
`define DBS_RD_B2_STG     4
`define DBS_PIPE          5

`endif

// *** hw/dbs_pkg.sv ***
// Types shared by the burst-of-two DDR SRAM interface block
package dbs_pkg;
  typedef logic [5:0] dbs_code_t;
  typedef enum logic [1:0] {
    DBS_CMD_NOP,
    DBS_CMD_RD,
    DBS_CMD_WR
  } dbs_cmd_t;
endpackage : dbs_pkg

// *** hw/dbs_sram.sv ***
// Command, data, DLL lock and impedance calibration logic of the SRAM
//
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "dbs_consts.svh"

module dbs_sram #(
  parameter int AW        = 4,
  parameter int DW        = 36,
  parameter int NB        = 4,
  parameter int LOCK_KCYC = `DBS_LOCK_KCYC
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  // Command pins, sampled at K rise; the write strobes are sampled with each data beat, at K rise and at K# rise
  input  wire logic                  load_strobe_n,
  input  wire logic                  read_write_sel,
  input  wire logic [AW-1:0]         addr,
  input  wire logic [NB-1:0]         byte_write_strobe_n,
  // Data pins
  input  wire logic [DW-1:0]         dq_i,
  output logic      [DW-1:0]         dq_o,
  output logic                       dq_oe,
  // DLL and clock status
  input  wire logic                  dll_enable,
  input  wire logic                  k_clock_running,
  // Impedance control
  input  wire logic [5:0]            impedance_ref_pin,
  input  wire logic                  termination_strength_select,
  output dbs_pkg::dbs_code_t         drive_code,
  output dbs_pkg::dbs_code_t         term_code,
  // Avalon-MM slave
  input  wire logic [3:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest
);

  localparam int DEPTH = 1 << AW;
  localparam int PIPE  = `DBS_PIPE;
  localparam int BW    = `DBS_BYTE_W;

  typedef struct packed {
    logic                          phase;
    logic [PIPE-1:0]               wv;
    logic [PIPE-1:0][AW-1:0]       wa;
    logic [PIPE-1:0]               rv;
    logic [PIPE-1:0][AW-1:0]       ra;
    logic [DEPTH-1:0][1:0][DW-1:0] mem;
    logic [DW-1:0]                 dq;
    logic                          oe;
    logic [3:0]                    stop_cnt;
    logic [11:0]                   lock_cnt;
    logic                          locked;
    logic [15:0]                   init_cnt;
    logic                          init_done;
    logic [31:0]                   cal_cnt;
    logic [31:0]                   cal_ival;
    logic                          cal_en;
    logic                          eval_req;
    dbs_pkg::dbs_code_t            drv;
    dbs_pkg::dbs_code_t            trm;
    logic                          ack;
    logic [31:0]                   rdata;
  } dbs_state_t;

  dbs_state_t st_q;
  dbs_state_t st_d;

  // ---------------------------------------------------------------
  // Byte masks from the write strobes
  // ---------------------------------------------------------------
  logic [DW-1:0] bmask;

  for (genvar g = 0; g < NB; g++) begin : g_mask
    assign bmask[g*BW +: BW] = {BW{~byte_write_strobe_n[g]}};
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic dbs_pkg::dbs_code_t step_to(
    input dbs_pkg::dbs_code_t cur,
    input dbs_pkg::dbs_code_t tgt
  );
    // One step only, so a noisy compare cannot slam the driver
    if (cur < tgt) begin
      step_to = cur + 6'h01;
    end else if (cur > tgt) begin
      step_to = cur - 6'h01;
    end else begin
      step_to = cur;
    end
  endfunction : step_to

  logic               k_edge;
  dbs_pkg::dbs_cmd_t  cmd;
  logic               stopped;
  logic               fire;
  logic [11:0]        tprod;
  dbs_pkg::dbs_code_t trm_tgt;
  logic               bus_req;

  assign k_edge  = ~st_q.phase;
  assign stopped = (st_q.stop_cnt >= 4'(`DBS_STOP_CYC));
  assign fire    = st_q.cal_en &&
                   (st_q.cal_cnt >= st_q.cal_ival || st_q.eval_req);
  assign bus_req = avs_read | avs_write;

  // Strong uses 0.3 of the reference code, weak 0.6
  assign tprod   = {6'h00, impedance_ref_pin} *
                   (termination_strength_select ? `DBS_WEAK_NUM
                                                : `DBS_STRONG_NUM);
  assign trm_tgt = 6'(tprod / `DBS_TERM_DEN);

  always_comb begin
    cmd = dbs_pkg::DBS_CMD_NOP;
    // Commands wait for lock; the controller is not expected to try
    if (k_edge && st_q.locked && !load_strobe_n) begin
      cmd = read_write_sel ? dbs_pkg::DBS_CMD_RD
                           : dbs_pkg::DBS_CMD_WR;
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.phase = ~st_q.phase;

    // Burst pipelines advance each half cycle
    st_d.wv = {st_q.wv[PIPE-2:0], cmd == dbs_pkg::DBS_CMD_WR};
    st_d.wa = {st_q.wa[PIPE-2:0], addr};
    st_d.rv = {st_q.rv[PIPE-2:0], cmd == dbs_pkg::DBS_CMD_RD};
    st_d.ra = {st_q.ra[PIPE-2:0], addr};

    // Late write: beat one at next K rise, beat two at K# rise
    if (st_q.wv[`DBS_WR_B1_STG]) begin
      st_d.mem[st_q.wa[`DBS_WR_B1_STG]][0] =
        (st_q.mem[st_q.wa[`DBS_WR_B1_STG]][0] & ~bmask) |
        (dq_i & bmask);
    end
    if (st_q.wv[`DBS_WR_B2_STG]) begin
      st_d.mem[st_q.wa[`DBS_WR_B2_STG]][1] =
        (st_q.mem[st_q.wa[`DBS_WR_B2_STG]][1] & ~bmask) |
        (dq_i & bmask);
    end

    // Drivers on only for read beats; else off, whatever the select
    st_d.oe = 1'b0;
    st_d.dq = '0;
    if (st_q.rv[`DBS_RD_B1_STG]) begin
      st_d.oe = 1'b1;
      st_d.dq = st_d.mem[st_q.ra[`DBS_RD_B1_STG]][0];
    end else if (st_q.rv[`DBS_RD_B2_STG]) begin
      st_d.oe = 1'b1;
      st_d.dq = st_d.mem[st_q.ra[`DBS_RD_B2_STG]][1];
    end

    // DLL lock tracking
    st_d.stop_cnt = k_clock_running ? 4'h0 :
                    (stopped ? st_q.stop_cnt : st_q.stop_cnt + 4'h1);
    if (!dll_enable || stopped) begin
      st_d.lock_cnt = 12'h000;
      st_d.locked   = 1'b0;
    end else if (k_edge && !st_q.locked) begin
      st_d.lock_cnt = st_q.lock_cnt + 12'h001;
      st_d.locked   = (st_q.lock_cnt == 12'(LOCK_KCYC - 1));
    end

    // Power-up interval seen once; DLL resets never clear it
    if (!st_q.init_done) begin
      st_d.init_cnt  = st_q.init_cnt + 16'h0001;
      st_d.init_done = (st_q.init_cnt == 16'(`DBS_INIT_CYC - 1));
    end

    // Periodic impedance evaluation for driver and termination
    st_d.cal_cnt = st_q.cal_cnt + 32'h0000_0001;
    if (fire) begin
      st_d.cal_cnt  = 32'h0000_0000;
      st_d.eval_req = 1'b0;
      st_d.drv      = step_to(st_q.drv, impedance_ref_pin);
      st_d.trm      = step_to(st_q.trm, trm_tgt);
    end

    // Avalon slave: one wait state on every access
    st_d.ack = bus_req && !st_q.ack;
    if (avs_read && !st_q.ack) begin
      unique case (avs_address)
        `DBS_OFF_CTRL: begin
          st_d.rdata = '0;
          st_d.rdata[`DBS_CTRL_CAL_EN] = st_q.cal_en;
          st_d.rdata[`DBS_CTRL_EVAL]   = st_q.eval_req;
        end
        `DBS_OFF_STAT: begin
          st_d.rdata = '0;
          st_d.rdata[`DBS_STAT_LOCKED] = st_q.locked;
          st_d.rdata[`DBS_STAT_INIT]   = st_q.init_done;
          st_d.rdata[`DBS_STAT_TSEL]   = termination_strength_select;
          st_d.rdata[`DBS_STAT_DRV +: 6] = st_q.drv;
          st_d.rdata[`DBS_STAT_TRM +: 6] = st_q.trm;
        end
        `DBS_OFF_IVAL: st_d.rdata = st_q.cal_ival;
        default:       st_d.rdata = '0;
      endcase
    end
    if (avs_write && st_q.ack) begin
      if (avs_address == `DBS_OFF_CTRL && avs_byteenable[0]) begin
        st_d.cal_en = avs_writedata[`DBS_CTRL_CAL_EN];
        if (avs_writedata[`DBS_CTRL_EVAL]) begin
          st_d.eval_req = 1'b1;
        end
      end
      if (avs_address == `DBS_OFF_IVAL) begin
        for (int b = 0; b < 4; b++) begin
          if (avs_byteenable[b]) begin
            st_d.cal_ival[b*8 +: 8] = avs_writedata[b*8 +: 8];
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q          <= '0;
      st_q.cal_ival <= `DBS_IVAL_RST;
      st_q.cal_en   <= 1'b1;
      st_q.drv      <= `DBS_CODE_RST;
      st_q.trm      <= `DBS_CODE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign dq_o            = st_q.dq;
  assign dq_oe           = st_q.oe;
  assign drive_code      = st_q.drv;
  // No disable path exists for the termination code
  assign term_code       = st_q.trm;
  assign avs_readdata    = st_q.rdata;
  assign avs_waitrequest = bus_req && !st_q.ack;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking dbs_cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  rd_latency_a: assert property (
    cmd == dbs_pkg::DBS_CMD_RD |-> ##5 dq_oe ##1 dq_oe)
    else $error("read data not driven at K edge n+2");

  turn_off_a: assert property (
    k_edge && cmd != dbs_pkg::DBS_CMD_RD |-> ##5 !dq_oe [*2])
    else $error("drivers on after nop or write");

  deselect_a: assert property (
    k_edge && load_strobe_n |=> !st_q.wv[0] && !st_q.rv[0])
    else $error("command taken while load strobe high");

  dll_reset_a: assert property (
    !dll_enable |=> !st_q.locked && st_q.lock_cnt == 12'h000)
    else $error("DLL kept lock while disabled");

  cal_step_a: assert property (
    (st_q.drv == $past(st_q.drv) ||
     st_q.drv == $past(st_q.drv) + 6'h01 ||
     st_q.drv == $past(st_q.drv) - 6'h01))
    else $error("drive code jumped more than one step");

  cal_restart_a: assert property (
    fire |=> st_q.cal_cnt == 32'h0000_0000)
    else $error("interval counter not restarted");

  wr_store_a: assert property (
    st_q.wv[1] && byte_write_strobe_n == '0 |=>
      st_q.mem[$past(st_q.wa[1])][0] == $past(dq_i))
    else $error("unmasked write beat not stored");

  wr_abort_a: assert property (
    st_q.wv[1] && &byte_write_strobe_n |=>
      st_q.mem[$past(st_q.wa[1])][0] ==
      $past(st_q.mem[st_q.wa[1]][0]))
    else $error("masked beat changed memory");

  bus_wait_a: assert property (
    bus_req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer took more than one wait state");

  trm_step_a: assert property (
    (st_q.trm == $past(st_q.trm) ||
     st_q.trm == $past(st_q.trm) + 6'h01 ||
     st_q.trm == $past(st_q.trm) - 6'h01))
    else $error("termination code jumped more than one step");

  rd_capture_a: assert property (
    k_edge && st_q.locked && !load_strobe_n && read_write_sel |=>
      st_q.rv[0] && st_q.ra[0] == $past(addr))
    else $error("read command not captured at K rise");

  wr_capture_a: assert property (
    k_edge && st_q.locked && !load_strobe_n && !read_write_sel |=>
      st_q.wv[0] && st_q.wa[0] == $past(addr))
    else $error("write command not captured at K rise");

  half_ignore_a: assert property (
    !k_edge |=> !st_q.wv[0] && !st_q.rv[0])
    else $error("command taken on a half-cycle edge");

  lock_gate_a: assert property (
    !st_q.locked |=> !st_q.wv[0] && !st_q.rv[0])
    else $error("command taken before DLL lock");

  wr_beat2_a: assert property (
    st_q.wv[2] && byte_write_strobe_n == '0 |=>
      st_q.mem[$past(st_q.wa[2])][1] == $past(dq_i))
    else $error("unmasked second beat not stored");

  oe_zero_a: assert property (
    !dq_oe |-> dq_o == '0)
    else $error("data driven while drivers off");

  init_once_a: assert property (
    st_q.init_done |=> st_q.init_done)
    else $error("power-up interval flag fell again");

  cal_hold_a: assert property (
    !st_q.cal_en |=> st_q.drv == $past(st_q.drv))
    else $error("drive code moved with calibration off");

  read_seen_c: cover property (cmd == dbs_pkg::DBS_CMD_RD ##5 dq_oe);
  eval_seen_c: cover property (st_q.eval_req && fire);
  write_seen_c: cover property (st_q.wv[2] && !(&byte_write_strobe_n));
  abort_seen_c: cover property (st_q.wv[1] && &byte_write_strobe_n);
  lock_seen_c: cover property ($rose(st_q.locked));

endmodule : dbs_sram

// *** sim/dbs_ctrl_model.sv ***
// Memory controller model driving the SRAM command and data pins
`timescale 1ns/1ps
module dbs_ctrl_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Command and data pins
  output logic             load_strobe_n,
  output logic             read_write_sel,
  output logic [3:0]       addr,
  output logic [3:0]       byte_write_strobe_n,
  output logic [35:0]      dq_i,
  input  wire logic [35:0] dq_o,
  input  wire logic        dq_oe
);
  logic kph_q;

  // Mirrors the device phase: an edge is a K edge when kph_q is low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) kph_q <= 1'b0;
    else kph_q <= ~kph_q;
  end

  initial begin
    load_strobe_n       = 1'b1;
    read_write_sel      = 1'b0;
    addr                = 4'h0;
    byte_write_strobe_n = 4'hF;
    dq_i                = 36'h0_0000_0000;
  end

  // Load strobe returns high; select and address flip so a stale value can never pass for a hold
  task automatic launch(input logic ld, input logic rw, input logic [3:0] a);
    do @(negedge clk); while (kph_q !== 1'b1);
    @(posedge clk);
    load_strobe_n  <= ld;
    read_write_sel <= rw;
    addr           <= a;
    @(posedge clk);
    load_strobe_n  <= 1'b1;
    read_write_sel <= ~rw;
    addr           <= ~a;
  endtask : launch

  task automatic wr(input logic ld, input logic [3:0] a,
                    input logic [35:0] d1, d2, input logic [3:0] s1, s2,
                    output logic e);
    launch(ld, 1'b0, a);
    @(posedge clk);
    dq_i                <= d1;
    byte_write_strobe_n <= s1;
    @(posedge clk);
    dq_i                <= d2;
    byte_write_strobe_n <= s2;
    @(posedge clk);
    dq_i                <= ~d2;
    byte_write_strobe_n <= 4'hF;
    @(posedge clk);
    @(negedge clk);
    e = dq_oe;
  endtask : wr

  task automatic rd(input logic ld, input logic [3:0] a,
                    output logic [35:0] q1, q2, output logic e1, e2);
    launch(ld, 1'b1, a);
    repeat (4) @(posedge clk);
    @(negedge clk);
    q1 = dq_o;
    e1 = dq_oe;
    @(negedge clk);
    q2 = dq_o;
    e2 = dq_oe;
  endtask : rd
endmodule : dbs_ctrl_model

// *** sim/dbs_sram_tb_top.sv ***
// Self-checking bench of the burst-of-two DDR SRAM interface
`timescale 1ns/1ps
module dbs_sram_tb_top;
  logic               clk, arst_n, dll_enable, k_clock_running;
  logic               termination_strength_select, dq_oe;
  logic               load_strobe_n, read_write_sel;
  logic [5:0]         impedance_ref_pin;
  logic [3:0]         addr, byte_write_strobe_n, avs_address;
  logic [35:0]        dq_i, dq_o;
  logic               avs_read, avs_write, avs_waitrequest;
  logic [31:0]        avs_writedata, avs_readdata, rdv;
  dbs_pkg::dbs_code_t drive_code, term_code;
  dbs_pkg::dbs_code_t drv_prev = 6'h20;
  dbs_pkg::dbs_code_t trm_prev = 6'h20;
  int                 n_fail, checked, seed, n;
  logic [35:0]        mem [16][2];
  logic [5:0]         r;

  dbs_sram #(.LOCK_KCYC(8)) dbs_sram_i (.clk(clk), .arst_n(arst_n),
    .load_strobe_n(load_strobe_n), .read_write_sel(read_write_sel),
    .addr(addr), .byte_write_strobe_n(byte_write_strobe_n), .dq_i(dq_i),
    .dq_o(dq_o), .dq_oe(dq_oe), .dll_enable(dll_enable),
    .k_clock_running(k_clock_running), .impedance_ref_pin(impedance_ref_pin),
    .termination_strength_select(termination_strength_select),
    .drive_code(drive_code), .term_code(term_code),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  dbs_ctrl_model dbs_ctrl_model_i (.clk(clk), .arst_n(arst_n),
    .load_strobe_n(load_strobe_n), .read_write_sel(read_write_sel),
    .addr(addr), .byte_write_strobe_n(byte_write_strobe_n), .dq_i(dq_i),
    .dq_o(dq_o), .dq_oe(dq_oe));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop

  function automatic logic [5:0] trm_exp(input logic [5:0] v, input logic s);
    return 6'(s ? int'(v) * 6 / 10 : int'(v) * 3 / 10);
  endfunction : trm_exp

  // Codes may move one step per evaluation, never more
  always @(negedge clk) begin
    if (arst_n === 1'b1) begin
      chk(36'((drv_prev - drive_code + 6'h01) <= 6'h02), 36'h1);
      chk(36'((trm_prev - term_code + 6'h01) <= 6'h02), 36'h1);
    end
    drv_prev = drive_code;
    trm_prev = term_code;
  end

  // ----------------------------------------------------------------
  // Bus and SRAM helpers
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
    logic wq;
    int   k;
    k = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_read      <= !w;
    avs_write     <= w;
    do begin
      @(negedge clk);
      wq = avs_waitrequest;
      @(posedge clk);
      k++;
    end while (wq !== 1'b0 && k < 50);
    if (k >= 50) begin
      n_fail++;
      report_and_stop();
    end
    rdv = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wait_st(input logic [1:0] m);
    int k;
    k = 0;
    do begin
      bus(1'b0, 4'h4, 32'h0000_0000);
      k++;
    end while ((rdv[1:0] & m) !== m && k < 200);
    if (k >= 200) begin
      n_fail++;
      report_and_stop();
    end
  endtask : wait_st

  task automatic do_wr(input logic ld, input logic [3:0] a,
                       input logic [35:0] d1, d2, input logic [3:0] s1, s2);
    logic e;
    dbs_ctrl_model_i.wr(ld, a, d1, d2, s1, s2, e);
    chk(e, 36'h0);
    for (int k = 0; k < 4; k++) begin
      if (!ld && !s1[k]) mem[a][0][9*k+:9] = d1[9*k+:9];
      if (!ld && !s2[k]) mem[a][1][9*k+:9] = d2[9*k+:9];
    end
  endtask : do_wr

  task automatic do_rd(input logic ld, input logic [3:0] a);
    logic [35:0] q1, q2;
    logic        e1, e2;
    dbs_ctrl_model_i.rd(ld, a, q1, q2, e1, e2);
    chk(e1, !ld);
    chk(e2, !ld);
    chk(q1, ld ? 36'h0 : mem[a][0]);
    chk(q2, ld ? 36'h0 : mem[a][1]);
  endtask : do_rd

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {arst_n, avs_read, avs_write, termination_strength_select} = 4'h0;
    {dll_enable, k_clock_running} = 2'b11;
    impedance_ref_pin = 6'h20;
    avs_address       = 4'h0;
    avs_writedata     = 32'h0000_0000;
    n_fail  = 0;
    checked = 0;
    seed    = 72501;
    repeat (16) @(posedge clk);
    chk(drive_code, 36'h20);
    chk(term_code, 36'h20);
    arst_n <= 1'b1;
    wait_st(2'b11);
    bus(1'b0, 4'hC, 32'h0000_0000);
    chk(rdv, 36'h0);
    for (int a = 0; a < 16; a++)
      do_wr(1'b0, 4'(a), 36'($random(seed)), 36'($random(seed)), 4'h0, 4'h0);
    for (int i = 0; i < 48; i++) begin
      @(posedge clk);
      termination_strength_select <= 1'($random(seed));
      do_wr(i % 7 == 3, 4'($random(seed)), 36'({$random(seed), $random(seed)}),
            36'({$random(seed), $random(seed)}),
            (i % 5 == 0) ? 4'hF : 4'($random(seed)),
            (i % 5 == 0) ? 4'hF : 4'($random(seed)));
      do_rd(i % 6 == 2, 4'($random(seed)));
    end
    for (int a = 0; a < 16; a++) do_rd(1'b0, 4'(a));
    @(posedge clk);
    dll_enable <= 1'b0;
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk(rdv[1:0], 36'h2);
    dll_enable <= 1'b1;
    wait_st(2'b01);
    k_clock_running <= 1'b0;
    @(posedge clk);
    k_clock_running <= 1'b1;
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk(rdv[0], 36'h0);
    wait_st(2'b01);
    do_rd(1'b0, 4'h5);
    bus(1'b1, 4'h8, 32'h0000_0010);
    for (int i = 0; i < 4; i++) begin
      r = (i == 0) ? 6'h3F : (i == 1) ? 6'h00 : 6'($random(seed));
      impedance_ref_pin           <= r;
      termination_strength_select <= i[0];
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while ((drive_code !== r || term_code !== trm_exp(r, i[0]))
                 && n < 3000);
      if (n >= 3000) begin
        n_fail++;
        report_and_stop();
      end
      bus(1'b0, 4'h4, 32'h0000_0000);
      chk(drive_code, r);
      chk(term_code, trm_exp(r, i[0]));
      chk(rdv[13:8], r);
      chk(rdv[2], i[0]);
    end
    // Evaluate-now with a long interval: exactly one step per request
    bus(1'b1, 4'h8, 32'h0001_0000);
    impedance_ref_pin <= r ^ 6'h01;
    bus(1'b1, 4'h0, 32'h0000_0003);
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk(rdv[13:8], r ^ 6'h01);
    bus(1'b0, 4'h0, 32'h0000_0000);
    chk(rdv[1:0], 36'h1);
    // Calibration off: a pending request must not move the code
    bus(1'b1, 4'h0, 32'h0000_0002);
    impedance_ref_pin <= ~r;
    repeat (40) @(posedge clk);
    chk(drive_code, r ^ 6'h01);
    bus(1'b0, 4'h0, 32'h0000_0000);
    chk(rdv[1:0], 36'h2);
    report_and_stop();
  end
endmodule : dbs_sram_tb_top
